//--- core/uwm_pkg.sv
// package: offsets, fields, reset values and carrier types for the window/msi slice
package uwm_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_WIN0_XBASE = 8'he0;
  localparam logic [7:0] OFF_WIN0_SETUP = 8'he4;
  localparam logic [7:0] OFF_WIN1_XBASE = 8'he8;
  localparam logic [7:0] OFF_WIN1_SETUP = 8'hec;
  localparam logic [7:0] OFF_MSI_CTRL   = 8'hf0;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int TYPE_SEL_BIT  = 0;
  localparam int ATYPE_LO      = 1;
  localparam int ATYPE_HI      = 2;
  localparam int PREF_BIT      = 3;
  localparam int WIN0_LO       = 12;
  localparam int WIN1_LO       = 6;
  localparam int MASK_HI       = 30;
  localparam int ENABLE_BIT    = 31;
  localparam int CAP_ID_LO     = 0;
  localparam int NEXT_PTR_LO   = 8;
  localparam int MSI_EN_BIT    = 16;
  localparam int MMC_LO        = 17;
  localparam int MME_LO        = 20;
  localparam int MME_HI        = 22;
  localparam int CAP64_BIT     = 23;

  // ----------------------------------------
  // reset and fixed values
  // ----------------------------------------
  localparam logic [1:0]  ATYPE_32     = 2'h0;
  localparam logic [1:0]  ATYPE_64     = 2'h1;
  localparam logic        TYPE_MEM     = 1'h0;
  localparam logic        PREF_RST     = 1'h0;
  localparam logic [18:0] MASK0_RST    = 19'h00000;
  localparam logic [24:0] MASK1_RST    = 25'h0000000;
  localparam logic        EN0_FIXED    = 1'h1;
  localparam logic        EN1_RST      = 1'h0;
  localparam logic [19:0] XBASE0_RST   = 20'h00000;
  localparam logic [25:0] XBASE1_RST   = 26'h0000000;
  localparam logic [7:0]  MSI_CAP_ID   = 8'h05;
  localparam logic [7:0]  MSI_NEXT_PTR = 8'h00;
  localparam logic [2:0]  MMC_VALUE    = 3'h0;
  localparam logic [2:0]  MME_RST      = 3'h0;
  localparam logic        MSI_EN_RST   = 1'h0;
  localparam logic        CAP64_RST    = 1'h1;
  localparam logic [31:0] RDATA_NONE   = 32'h00000000;

  // ----------------------------------------
  // interrupt pins and synchroniser
  // ----------------------------------------
  localparam int          NUM_INTX     = 4;
  localparam logic        SYNC_RST     = 1'h1;

  // ----------------------------------------
  // carrier types
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        side_load_write;
  } uwm_reg_req_t;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic [31:0] addr;
  } uwm_txn_t;

  typedef struct packed {
    logic        valid;
    logic        hit0;
    logic        hit1;
    logic [31:0] addr;
  } uwm_txn_out_t;

endpackage

//--- core/uwm_pin_sync.sv
// three-flop input synchroniser per interrupt pin, change taken when stages two and three agree
`timescale 1ns/1ps
module uwm_pin_sync #(
  parameter int N = 4
) (
  input  wire logic         clk,       // core clock
  input  wire logic         rst_n,     // async reset, active low
  input  wire logic [N-1:0] pin_in,    // asynchronous pin levels
  output logic      [N-1:0] pin_out    // filtered synchronous levels
);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_reg <= uwm_pkg::SYNC_RST;
          s2_reg <= uwm_pkg::SYNC_RST;
          s3_reg <= uwm_pkg::SYNC_RST;
        end else begin
          s1_reg <= pin_in[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_out[g] <= uwm_pkg::SYNC_RST;
        end else if (s2_reg == s3_reg) begin
          pin_out[g] <= s3_reg;
        end
      end
    end
  endgenerate

endmodule

//--- core/uwm_win_xlate.sv
// one upstream window: hit detect against its base and masked address replacement
`timescale 1ns/1ps
module uwm_win_xlate #(
  parameter int LO = 12
) (
  input  wire logic          clk,      // core clock
  input  wire logic          rst_n,    // async reset, active low
  input  wire logic          en,       // window enable
  input  wire logic          allow_io, // window accepts i/o cycles
  input  wire uwm_pkg::uwm_txn_t txn,  // incoming upstream transaction
  input  wire logic [31:0]   bar_base, // window base address
  input  wire logic [30:LO]  mask,     // size mask, 1 = bit left out of hit compare and taken from xbase
  input  wire logic [31:LO]  xbase,    // translated base
  output logic               hit,      // registered hit
  output logic      [31:0]   addr_out  // registered translated address
);

  logic [31:LO] sel;
  logic [31:LO] cmp;
  logic         hit_now;

  always_comb begin
    sel     = {1'b0, mask};
    cmp     = (txn.addr[31:LO] ^ bar_base[31:LO]) & ~sel;
    hit_now = txn.valid && en && (allow_io || !txn.is_io) && (cmp == '0);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit      <= 1'b0;
      addr_out <= 32'h00000000;
    end else begin
      hit      <= hit_now;
      // swap masked bits for translated base, keep low offset
      addr_out <= {(txn.addr[31:LO] & ~sel) | (xbase & sel), txn.addr[LO-1:0]};
    end
  end

endmodule

//--- core/uwm_regs.sv
// upstream window setup, translated bases and msi control word with address translation
`timescale 1ns/1ps
module uwm_regs (
  input  wire logic                  clk,          // core clock, 10 MHz
  input  wire logic                  rst_n,        // async reset, active low
  input  wire uwm_pkg::uwm_reg_req_t req,          // register access request
  output logic                [31:0] rdata,        // read data, cycle after read
  input  wire uwm_pkg::uwm_txn_t     txn,          // upstream transaction in
  input  wire logic           [31:0] win0_bar,     // window 0 base address
  input  wire logic           [31:0] win1_bar,     // window 1 base address
  output uwm_pkg::uwm_txn_out_t      txn_out,      // translated transaction
  input  wire logic [uwm_pkg::NUM_INTX-1:0] intx_pin_n, // interrupt pins, low active
  output logic [uwm_pkg::NUM_INTX-1:0] intx_out_n, // intx forwarded when msi off
  output logic                       msi_req,      // pulse: msi message wanted
  output logic                       msi_mode,     // msi enable state
  output logic                [2:0]  msi_mme       // allocated message code
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [1:0]  atype0_reg;
  logic        pref0_reg;
  logic [18:0] mask0_reg;
  logic [19:0] xbase0_reg;
  logic [1:0]  atype1_reg;
  logic        pref1_reg;
  logic [24:0] mask1_reg;
  logic        en1_reg;
  logic [25:0] xbase1_reg;
  logic        msi_en_reg;
  logic [2:0]  mme_reg;
  logic        cap64_reg;

  logic        wr_any;
  logic        sl;
  logic [31:0] wd;

  always_comb begin
    sl     = req.side_load_write;
    wr_any = req.wr || sl;
    wd     = req.wdata;
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  logic        hit_xbase0;
  logic        hit_setup0;
  logic        hit_xbase1;
  logic        hit_setup1;
  logic        hit_msi;

  // one decode per register, shared by every write path
  always_comb begin
    hit_xbase0 = (req.addr == uwm_pkg::OFF_WIN0_XBASE);
    hit_setup0 = (req.addr == uwm_pkg::OFF_WIN0_SETUP);
    hit_xbase1 = (req.addr == uwm_pkg::OFF_WIN1_XBASE);
    hit_setup1 = (req.addr == uwm_pkg::OFF_WIN1_SETUP);
    hit_msi    = (req.addr == uwm_pkg::OFF_MSI_CTRL);
  end

  // ----------------------------------------
  // window 0 setup and translated base
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      atype0_reg <= uwm_pkg::ATYPE_32;
      pref0_reg  <= uwm_pkg::PREF_RST;
      mask0_reg  <= uwm_pkg::MASK0_RST;
    end else if (sl && hit_setup0) begin
      atype0_reg <= wd[uwm_pkg::ATYPE_HI:uwm_pkg::ATYPE_LO];
      pref0_reg  <= wd[uwm_pkg::PREF_BIT];
      mask0_reg  <= wd[uwm_pkg::MASK_HI:uwm_pkg::WIN0_LO];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xbase0_reg <= uwm_pkg::XBASE0_RST;
    end else if (wr_any && hit_xbase0) begin
      xbase0_reg <= wd[31:uwm_pkg::WIN0_LO];
    end
  end

  // ----------------------------------------
  // window 1 setup and translated base
  // ----------------------------------------
  // only the side-load path opens or closes window 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      atype1_reg <= uwm_pkg::ATYPE_32;
      pref1_reg  <= uwm_pkg::PREF_RST;
      mask1_reg  <= uwm_pkg::MASK1_RST;
      en1_reg    <= uwm_pkg::EN1_RST;
    end else if (sl && hit_setup1) begin
      atype1_reg <= wd[uwm_pkg::ATYPE_HI:uwm_pkg::ATYPE_LO];
      pref1_reg  <= wd[uwm_pkg::PREF_BIT];
      mask1_reg  <= wd[uwm_pkg::MASK_HI:uwm_pkg::WIN1_LO];
      en1_reg    <= wd[uwm_pkg::ENABLE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xbase1_reg <= uwm_pkg::XBASE1_RST;
    end else if (wr_any && hit_xbase1) begin
      xbase1_reg <= wd[31:uwm_pkg::WIN1_LO];
    end
  end

  // ----------------------------------------
  // msi message control
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msi_en_reg <= uwm_pkg::MSI_EN_RST;
    end else if (wr_any && hit_msi) begin
      msi_en_reg <= wd[uwm_pkg::MSI_EN_BIT];
    end
  end

  // reserved codes are kept as written, software owns the choice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mme_reg <= uwm_pkg::MME_RST;
    end else if (wr_any && hit_msi) begin
      mme_reg <= wd[uwm_pkg::MME_HI:uwm_pkg::MME_LO];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap64_reg <= uwm_pkg::CAP64_RST;
    end else if (wr_any && hit_msi) begin
      cap64_reg <= wd[uwm_pkg::CAP64_BIT];
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = uwm_pkg::RDATA_NONE;
    unique case (req.addr)
      uwm_pkg::OFF_WIN0_XBASE: rd_mux = {xbase0_reg, 12'h000};
      uwm_pkg::OFF_WIN0_SETUP: begin
        rd_mux[uwm_pkg::TYPE_SEL_BIT] = uwm_pkg::TYPE_MEM;
        rd_mux[uwm_pkg::ATYPE_HI:uwm_pkg::ATYPE_LO] = atype0_reg;
        rd_mux[uwm_pkg::PREF_BIT] = pref0_reg;
        rd_mux[uwm_pkg::MASK_HI:uwm_pkg::WIN0_LO] = mask0_reg;
        rd_mux[uwm_pkg::ENABLE_BIT] = uwm_pkg::EN0_FIXED;
      end
      uwm_pkg::OFF_WIN1_XBASE: rd_mux = {xbase1_reg, 6'h00};
      uwm_pkg::OFF_WIN1_SETUP: begin
        rd_mux[uwm_pkg::TYPE_SEL_BIT] = uwm_pkg::TYPE_MEM;
        rd_mux[uwm_pkg::ATYPE_HI:uwm_pkg::ATYPE_LO] = atype1_reg;
        rd_mux[uwm_pkg::PREF_BIT] = pref1_reg;
        rd_mux[uwm_pkg::MASK_HI:uwm_pkg::WIN1_LO] = mask1_reg;
        rd_mux[uwm_pkg::ENABLE_BIT] = en1_reg;
      end
      uwm_pkg::OFF_MSI_CTRL: begin
        rd_mux[uwm_pkg::NEXT_PTR_LO-1:uwm_pkg::CAP_ID_LO] = uwm_pkg::MSI_CAP_ID;
        rd_mux[uwm_pkg::MSI_EN_BIT-1:uwm_pkg::NEXT_PTR_LO] = uwm_pkg::MSI_NEXT_PTR;
        rd_mux[uwm_pkg::MSI_EN_BIT] = msi_en_reg;
        rd_mux[uwm_pkg::MME_LO-1:uwm_pkg::MMC_LO] = uwm_pkg::MMC_VALUE;
        rd_mux[uwm_pkg::MME_HI:uwm_pkg::MME_LO] = mme_reg;
        rd_mux[uwm_pkg::CAP64_BIT] = cap64_reg;
      end
      default: rd_mux = uwm_pkg::RDATA_NONE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= uwm_pkg::RDATA_NONE;
    end else if (req.rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= uwm_pkg::RDATA_NONE;
    end
  end

  // ----------------------------------------
  // address translation
  // ----------------------------------------
  logic        hit0;
  logic        hit1;
  logic [31:0] a0;
  logic [31:0] a1;
  logic        vld_d;
  logic [31:0] addr_d;

  uwm_win_xlate #(.LO(uwm_pkg::WIN0_LO)) u_win0 (
    .clk      (clk),
    .rst_n    (rst_n),
    .en       (uwm_pkg::EN0_FIXED),
    .allow_io (1'b0),
    .txn      (txn),
    .bar_base (win0_bar),
    .mask     (mask0_reg),
    .xbase    (xbase0_reg),
    .hit      (hit0),
    .addr_out (a0)
  );

  uwm_win_xlate #(.LO(uwm_pkg::WIN1_LO)) u_win1 (
    .clk      (clk),
    .rst_n    (rst_n),
    .en       (en1_reg),
    .allow_io (1'b1),
    .txn      (txn),
    .bar_base (win1_bar),
    .mask     (mask1_reg),
    .xbase    (xbase1_reg),
    .hit      (hit1),
    .addr_out (a1)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vld_d  <= 1'b0;
      addr_d <= 32'h00000000;
    end else begin
      vld_d  <= txn.valid;
      addr_d <= txn.addr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txn_out <= '0;
    end else begin
      txn_out.valid <= vld_d;
      txn_out.hit0  <= hit0;
      txn_out.hit1  <= hit1 && !hit0;
      // window 0 wins on overlap, a miss passes unchanged
      txn_out.addr  <= hit0 ? a0 : (hit1 ? a1 : addr_d);
    end
  end

  // ----------------------------------------
  // interrupt path selection
  // ----------------------------------------
  logic [uwm_pkg::NUM_INTX-1:0] pin_s;
  logic [uwm_pkg::NUM_INTX-1:0] pin_prev_reg;

  uwm_pin_sync #(.N(uwm_pkg::NUM_INTX)) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_in  (intx_pin_n),
    .pin_out (pin_s)
  );

  // with msi enabled, any synced pin going low asks for one message
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_reg <= '1;
      msi_req      <= 1'b0;
    end else begin
      pin_prev_reg <= pin_s;
      msi_req      <= msi_en_reg && |(pin_prev_reg & ~pin_s);
    end
  end

  // msi mode hides the pins from the legacy path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intx_out_n <= '1;
    end else begin
      intx_out_n <= msi_en_reg ? '1 : pin_s;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msi_mode <= uwm_pkg::MSI_EN_RST;
      msi_mme  <= uwm_pkg::MME_RST;
    end else begin
      msi_mode <= msi_en_reg;
      msi_mme  <= mme_reg;
    end
  end

endmodule

//--- sim/uwm_regs_properties.sv
// checker on the ports of the window/msi register slice
`timescale 1ns/1ps
module uwm_regs_properties (
  input wire logic                            clk,        // clock
  input wire logic                            rst_n,      // reset, low
  input wire uwm_pkg::uwm_reg_req_t           req,        // request
  input wire logic [31:0]                     rdata,      // read data
  input wire uwm_pkg::uwm_txn_t               txn,        // txn in
  input wire logic [31:0]                     win0_bar,   // base 0
  input wire logic [31:0]                     win1_bar,   // base 1
  input wire uwm_pkg::uwm_txn_out_t           txn_out,    // txn out
  input wire logic [uwm_pkg::NUM_INTX-1:0]    intx_pin_n, // pins
  input wire logic [uwm_pkg::NUM_INTX-1:0]    intx_out_n, // forwarded
  input wire logic                            msi_req,    // msi pulse
  input wire logic                            msi_mode,   // msi on
  input wire logic [2:0]                      msi_mme     // mme code
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  idle_rdata_a: assert property (!$past(req.rd) |-> rdata == 32'h00000000)
    else $error("read data not zero outside answer");
  win0_fixed_a: assert property ($past(req.rd) && $past(req.addr) == 8'he4 |->
    rdata[31] && !rdata[0] && rdata[11:4] == 8'h00) else $error("window 0 setup bad");
  win1_type_a: assert property ($past(req.rd) && $past(req.addr) == 8'hec |->
    !rdata[0] && rdata[5:4] == 2'h0) else $error("window 1 setup bad");
  xbase0_low_a: assert property ($past(req.rd) && $past(req.addr) == 8'he0 |->
    rdata[11:0] == 12'h000) else $error("base 0 low bits set");
  xbase1_rw_a: assert property ($past(req.wr, 2) && $past(req.addr, 2) == 8'he8
    && $past(req.rd) && $past(req.addr) == 8'he8 |->
    rdata == {$past(req.wdata[31:6], 2), 6'h00}) else $error("base 1 readback bad");
  msi_head_a: assert property ($past(req.rd) && $past(req.addr) == 8'hf0 |->
    rdata[15:0] == 16'h0005 && rdata[19:17] == 3'h0) else $error("msi header bad");
  xlate_lat_a: assert property (txn_out.valid == $past(txn.valid, 2))
    else $error("translation latency wrong");
  miss_pass_a: assert property (txn_out.valid && !txn_out.hit0 && !txn_out.hit1 |->
    txn_out.addr == $past(txn.addr, 2)) else $error("miss address altered");
  intx_mask_a: assert property (msi_mode && $past(msi_mode) |-> intx_out_n == 4'hf)
    else $error("intx not masked in msi mode");
  msi_pulse_a: assert property (msi_req |=> !msi_req)
    else $error("msi request longer than one cycle");

  hit0_c: cover property (txn_out.valid && txn_out.hit0);
  hit1_c: cover property (txn_out.valid && txn_out.hit1);
  msi_c: cover property (msi_req);
endmodule

bind uwm_regs uwm_regs_properties i_props (
  .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .txn(txn), .win0_bar(win0_bar),
  .win1_bar(win1_bar), .txn_out(txn_out), .intx_pin_n(intx_pin_n),
  .intx_out_n(intx_out_n), .msi_req(msi_req), .msi_mode(msi_mode), .msi_mme(msi_mme)
);

//--- sim/tb.sv
// self-checking bench for the window/msi register slice
`timescale 1ns/1ps
module tb;
  typedef struct {
    int          op;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [31:0] exp;
  } uwm_row_t;

  logic                  clk;
  logic                  rst_n;
  uwm_pkg::uwm_reg_req_t req;
  logic [31:0]           rdata;
  uwm_pkg::uwm_txn_t     txn;
  uwm_pkg::uwm_txn_out_t txn_out;
  logic [3:0]            intx_pin_n;
  logic [3:0]            intx_out_n;
  logic                  msi_req;
  logic                  msi_mode;
  logic [2:0]            msi_mme;
  int                    miscompares = 0;
  int                    num_checks = 0;
  int                    cycles = 0;
  int                    pulses = 0;
  // op 0 write, 1 side-load write, 2 read
  uwm_row_t rows [26] = '{
    '{2, 8'he0, 32'h0, 32'h00000000}, '{2, 8'he4, 32'h0, 32'h80000000},
    '{2, 8'he8, 32'h0, 32'h00000000}, '{2, 8'hec, 32'h0, 32'h00000000},
    '{2, 8'hf0, 32'h0, 32'h00800005}, '{2, 8'h00, 32'h0, 32'h00000000},
    '{0, 8'he4, 32'hffffffff, 32'h0}, '{2, 8'he4, 32'h0, 32'h80000000},
    '{0, 8'hec, 32'hffffffff, 32'h0}, '{2, 8'hec, 32'h0, 32'h00000000},
    '{0, 8'he0, 32'habcdefff, 32'h0}, '{2, 8'he0, 32'h0, 32'habcde000},
    '{0, 8'he8, 32'h1234ffff, 32'h0}, '{2, 8'he8, 32'h0, 32'h1234ffc0},
    '{0, 8'hf0, 32'hffffffff, 32'h0}, '{2, 8'hf0, 32'h0, 32'h00f10005},
    '{0, 8'h00, 32'hffffffff, 32'h0}, '{2, 8'h00, 32'h0, 32'h00000000},
    '{1, 8'he4, 32'h7ffffff3, 32'h0}, '{2, 8'he4, 32'h0, 32'hfffff002},
    '{1, 8'hec, 32'h8000f03b, 32'h0}, '{2, 8'hec, 32'h0, 32'h8000f00a},
    '{0, 8'hec, 32'h00000000, 32'h0}, '{2, 8'hec, 32'h0, 32'h8000f00a},
    '{0, 8'he4, 32'h00000000, 32'h0}, '{2, 8'he4, 32'h0, 32'hfffff002}
  };

  uwm_regs i_uwm_regs (
    .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .txn(txn),
    .win0_bar(32'h80000000), .win1_bar(32'h40000000), .txn_out(txn_out),
    .intx_pin_n(intx_pin_n), .intx_out_n(intx_out_n), .msi_req(msi_req),
    .msi_mode(msi_mode), .msi_mme(msi_mme)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one-cycle strobe, then all strobes low; a read returns while its data stand
  task automatic acc(input int op, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= (op == 0);
    req.rd <= (op == 2);
    req.side_load_write <= (op == 1);
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    req.side_load_write <= 1'b0;
    #1;
  endtask

  task automatic xl(input logic io, input logic [31:0] a, input logic [31:0] ea,
                    input logic [1:0] eh);
    @(posedge clk);
    txn <= '{valid: 1'b1, is_io: io, addr: a};
    @(posedge clk);
    txn.valid <= 1'b0;
    @(posedge clk);
    #1;
    check({31'h0, txn_out.valid}, 32'h00000001);
    check(txn_out.addr, ea);
    check({30'h0, txn_out.hit0, txn_out.hit1}, {30'h0, eh});
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (msi_req === 1'b1) pulses++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    req = '0;
    txn = '0;
    intx_pin_n = 4'hf;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      acc(rows[i].op, rows[i].addr, rows[i].data);
      if (rows[i].op == 2) check(rdata, rows[i].exp);
    end
    for (int c = 0; c < 8; c++) begin
      acc(0, 8'hf0, {8'h00, 1'b1, 3'(c), 20'h00000});
      acc(2, 8'hf0, 32'h0);
      check(rdata, {8'h00, 1'b1, 3'(c), 20'h00005});
      check({29'h0, msi_mme}, {29'h0, 3'(c)});
    end
    xl(1'b0, 32'h4000303c, 32'h4000f03c, 2'b01);
    xl(1'b0, 32'h80000123, 32'habcde123, 2'b10);
    xl(1'b0, 32'h40013abc, 32'h40013abc, 2'b00);
    xl(1'b1, 32'h4000303c, 32'h4000f03c, 2'b01);
    xl(1'b1, 32'h80000123, 32'h80000123, 2'b00);
    // back to back write then read of window 1 translated base
    @(posedge clk);
    req.addr <= 8'he8;
    req.wdata <= 32'h0badf00d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check(rdata, 32'h0badf000);
    acc(1, 8'hec, 32'h0000f00a);
    acc(2, 8'hec, 32'h0);
    check(rdata, 32'h0000f00a);
    xl(1'b0, 32'h4000303c, 32'h4000303c, 2'b00);
    @(posedge clk);
    intx_pin_n <= 4'he;
    repeat (8) @(posedge clk);
    #1;
    check({28'h0, intx_out_n}, 32'h0000000e);
    acc(0, 8'hf0, 32'h00810000);
    acc(2, 8'hf0, 32'h0);
    check(rdata, 32'h00810005);
    pulses = 0;
    @(posedge clk);
    intx_pin_n <= 4'hc;
    repeat (12) @(posedge clk);
    #1;
    check(pulses, 32'h1);
    check({28'h0, intx_out_n}, 32'h0000000f);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    acc(2, 8'he8, 32'h0);
    check(rdata, 32'h00000000);
    acc(2, 8'hf0, 32'h0);
    check(rdata, 32'h00800005);
    check({31'h0, msi_mode}, 32'h0);
    final_report();
  end
endmodule
